/* File: hdl/sbl_echo.sv */
// Purpose: one-byte holding register that echoes received characters
// Assumes: load only while o_ready is high
// Notes:   a slow transmitter stalls the receive side through o_ready
`timescale 1ns/1ps
module sbl_echo (
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_load,
    input  wire logic [7:0] i_byte,
    output logic            o_ready,
    output logic            o_tx_valid,
    output logic [7:0]      o_tx_data,
    input  wire logic       i_tx_ready
);
    logic       full_ff;
    logic [7:0] data_ff;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            full_ff <= 1'b0;
        end else if (i_load) begin
            full_ff <= 1'b1;
        end else if (i_tx_ready) begin
            full_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            data_ff <= 8'h00;
        end else if (i_load) begin
            data_ff <= i_byte;    // see R13
        end
    end

    assign o_ready    = ~full_ff;
    assign o_tx_valid = full_ff;
    assign o_tx_data  = data_ff;
endmodule

/* File: hdl/sbl_loader.sv */
// Purpose: serial boot loader sequencer with a wishbone status port
// Assumes: rx/tx byte streams are the first serial channel's uart, ram is dual-port
// Notes:   configuration images are driven to the serial channel as levels
//
// Register access over Wishbone and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "sbl_params.svh"
module sbl_loader (
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_boot_strap_pin,
    input  wire logic                 i_boot_clock_select_pin,
    input  wire logic                 i_freq_select_pin,
    input  wire sbl_pkg::sbl_wb_req_t i_wb,
    output sbl_pkg::sbl_wb_rsp_t      o_wb,
    input  wire logic                 i_rx_valid,
    input  wire logic [7:0]           i_rx_data,
    output logic                      o_rx_ready,
    output logic                      o_tx_valid,
    output logic [7:0]                o_tx_data,
    input  wire logic                 i_tx_ready,
    output sbl_pkg::sbl_ram_wr_t      o_ram,
    output sbl_pkg::sbl_scc_cfg_t     o_scc_cfg,
    output logic                      o_core_halt
);
    import sbl_pkg::*;

    // ------------------------------------------------------------
    // types and state
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_START,
        ST_SET_BAR,
        ST_WAIT_CLKSEL,
        ST_SET_CLK,
        ST_SET_SCM,
        ST_RECV,
        ST_UART_OFF,
        ST_RELEASE,
        ST_IDLE
    } sbl_state_t;

    sbl_state_t              state_ff;
    sbl_scc_cfg_t            cfg_ff;
    sbl_ram_wr_t             ram_ff;
    logic                    halt_ff;
    logic                    done_ff;
    logic                    hold_ff;
    logic [`SBL_RAM_AW-1:0]  cnt_ff;
    logic                    ack_ff;
    logic                    err_ff;
    logic [31:0]             rdat_ff;

    logic                    boot_en;
    logic                    freq_sel;
    logic                    clk_ext;
    logic                    clksel_valid;
    logic                    echo_ready;
    logic                    accept;
    logic                    wb_hit;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic is_mapped(input logic [7:0] adr);
        is_mapped = (adr == `SBL_REG_CTRL) || (adr == `SBL_REG_STATUS) ||
                    (adr == `SBL_REG_SCC)  || (adr == `SBL_REG_SYS);
    endfunction

    function automatic logic is_last(input logic [`SBL_RAM_AW-1:0] cnt);
        is_last = (cnt == `SBL_IMAGE_BYTES - 1'b1);
    endfunction

    // ------------------------------------------------------------
    // straps and echo
    // ------------------------------------------------------------
    sbl_strap u_strap (
        .i_ref_clk               (i_ref_clk),
        .i_rst_n                 (i_rst_n),
        .i_boot_strap_pin        (i_boot_strap_pin),
        .i_boot_clock_select_pin (i_boot_clock_select_pin),
        .i_freq_select_pin       (i_freq_select_pin),
        .o_boot_en               (boot_en),
        .o_input_freq_select     (freq_sel),
        .o_clk_ext               (clk_ext),
        .o_clksel_valid          (clksel_valid)
    );

    sbl_echo u_echo (
        .i_ref_clk  (i_ref_clk),
        .i_rst_n    (i_rst_n),
        .i_load     (accept),
        .i_byte     (i_rx_data),
        .o_ready    (echo_ready),
        .o_tx_valid (o_tx_valid),
        .o_tx_data  (o_tx_data),
        .i_tx_ready (i_tx_ready)
    );

    // only channel one feeds the loader; a busy echo stalls reception
    assign o_rx_ready = (state_ff == ST_RECV) && echo_ready && !hold_ff;    // see R21 R13
    assign accept     = o_rx_ready && i_rx_valid;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            state_ff <= ST_START;
        end else begin
            case (state_ff)
                ST_START: begin
                    state_ff <= boot_en ? ST_SET_BAR : ST_IDLE;    // see R1
                end
                ST_SET_BAR: begin
                    state_ff <= ST_WAIT_CLKSEL;
                end
                ST_WAIT_CLKSEL: begin
                    if (clksel_valid) begin
                        state_ff <= ST_SET_CLK;
                    end
                end
                ST_SET_CLK: begin
                    state_ff <= ST_SET_SCM;
                end
                ST_SET_SCM: begin
                    state_ff <= ST_RECV;
                end
                ST_RECV: begin
                    if (accept && is_last(cnt_ff)) begin
                        state_ff <= ST_UART_OFF;    // see R14
                    end
                end
                ST_UART_OFF: begin
                    state_ff <= ST_RELEASE;
                end
                ST_RELEASE: begin
                    state_ff <= ST_IDLE;
                end
                ST_IDLE: begin
                    state_ff <= ST_IDLE;    // see R23 R18
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // held through reset; with boot enabled stays up until the image is in and the uart is off
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            halt_ff <= 1'b1;    // see R5
        end else if ((state_ff == ST_START && !boot_en) || state_ff == ST_RELEASE) begin
            halt_ff <= 1'b0;    // see R17
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            done_ff <= 1'b0;
        end else if (state_ff == ST_RELEASE) begin
            done_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // serial channel configuration images
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            cfg_ff.bar          <= `SBL_BAR_RESET;
            cfg_ff.interrupt_config_register          <= `SBL_ICR_RESET;
            cfg_ff.scon         <= `SBL_SCON_RESET;
            cfg_ff.serial_mode_register          <= `SBL_SCM_RESET;
            cfg_ff.ext_clk      <= 1'b0;
            cfg_ff.clk_pins_hiz <= 1'b0;
            cfg_ff.autobaud     <= 1'b0;
        end else begin
            cfg_ff.autobaud <= 1'b0;    // see R22
            case (state_ff)
                ST_SET_BAR: begin
                    cfg_ff.bar <= `SBL_BAR_BOOT;    // see R6
                end
                ST_SET_CLK: begin
                    cfg_ff.ext_clk      <= clk_ext;     // see R7
                    cfg_ff.clk_pins_hiz <= ~clk_ext;    // see R8
                    if (!clk_ext) begin
                        // divider bits are don't-care with pin clocks
                        cfg_ff.scon <= freq_sel ? `SBL_SCON_32K : `SBL_SCON_4M;    // see R9 R10
                    end
                end
                ST_SET_SCM: begin
                    cfg_ff.serial_mode_register <= `SBL_SCM_UART;    // see R11
                    cfg_ff.interrupt_config_register <= `SBL_ICR_BOOT;    // see R19
                end
                ST_UART_OFF: begin
                    cfg_ff.serial_mode_register <= `SBL_SCM_RESET;    // see R16
                end
                default: begin
                    cfg_ff.serial_mode_register <= cfg_ff.serial_mode_register;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // image store: no error check, bytes land as they arrive
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            cnt_ff <= '0;
        end else if (accept) begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            ram_ff <= '0;
        end else begin
            ram_ff.we <= accept;
            if (accept) begin
                ram_ff.addr <= cnt_ff;       // see R12
                ram_ff.data <= i_rx_data;
            end
        end
    end

    // ------------------------------------------------------------
    // wishbone slave: one wait state, err on unmapped address
    // ------------------------------------------------------------
    assign wb_hit = i_wb.cyc && i_wb.stb && !ack_ff && !err_ff;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
        end else begin
            ack_ff <= wb_hit && is_mapped(i_wb.adr);
            err_ff <= wb_hit && !is_mapped(i_wb.adr);
        end
    end

    // hold is a debug throttle: reception pauses but nothing is dropped
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            hold_ff <= 1'b0;
        end else if (wb_hit && i_wb.we && i_wb.sel[0] && i_wb.adr == `SBL_REG_CTRL) begin
            hold_ff <= i_wb.dat[`SBL_CTRL_HOLD];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            rdat_ff <= 32'h0000_0000;
        end else if (wb_hit) begin
            case (i_wb.adr)
                `SBL_REG_CTRL: begin
                    rdat_ff <= {31'h0000_0000, hold_ff};
                end
                `SBL_REG_STATUS: begin
                    rdat_ff <= {10'h000, clksel_valid, done_ff, freq_sel, clk_ext,
                                boot_en, halt_ff, 6'h00, cnt_ff};
                end
                `SBL_REG_SCC: begin
                    rdat_ff <= {cfg_ff.serial_mode_register, cfg_ff.scon};
                end
                `SBL_REG_SYS: begin
                    rdat_ff <= {cfg_ff.interrupt_config_register, cfg_ff.bar};
                end
                default: begin
                    rdat_ff <= 32'h0000_0000;
                end
            endcase
        end
    end

    assign o_wb.ack    = ack_ff;
    assign o_wb.err    = err_ff;
    assign o_wb.dat    = rdat_ff;
    assign o_ram       = ram_ff;
    assign o_scc_cfg   = cfg_ff;
    assign o_core_halt = halt_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    halt_in_boot_a: assert property ( // see R5
        (state_ff != ST_START && boot_en && !done_ff) |-> halt_ff)
        else $error("core halt dropped before boot finished");
    bar_first_a: assert property ( // see R6
        (state_ff == ST_SET_BAR) |=> cfg_ff.bar == `SBL_BAR_BOOT && state_ff == ST_WAIT_CLKSEL)
        else $error("base address not cleared before clock select");
    clk_pins_a: assert property ( // see R7 R8
        (state_ff == ST_SET_CLK) |=> cfg_ff.clk_pins_hiz == !cfg_ff.ext_clk
                                     && cfg_ff.ext_clk == $past(clk_ext))
        else $error("clock pin mode does not follow clock select");
    scon_value_a: assert property ( // see R9
        (state_ff == ST_SET_CLK && !clk_ext)
        |=> cfg_ff.scon == ($past(freq_sel) ? `SBL_SCON_32K : `SBL_SCON_4M))
        else $error("divider image wrong for frequency strap");
    div_field_a: assert property ( // see R10
        (state_ff == ST_RECV && !cfg_ff.ext_clk && freq_sel)
        |-> cfg_ff.scon[`SBL_DIV_MSB:`SBL_DIV_LSB] == `SBL_DIV_32K)
        else $error("divider field not 84 for 32 kHz input");
    scm_uart_a: assert property ( // see R11
        (state_ff == ST_RECV) |-> cfg_ff.serial_mode_register == `SBL_SCM_UART && !cfg_ff.autobaud)
        else $error("mode image not uart during reception");
    ram_store_a: assert property ( // see R12
        accept |=> ram_ff.we && ram_ff.addr == $past(cnt_ff) && ram_ff.data == $past(i_rx_data))
        else $error("byte not stored at running address");
    echo_byte_a: assert property ( // see R13
        accept |=> o_tx_valid && o_tx_data == $past(i_rx_data))
        else $error("received byte not echoed");
    exact_count_a: assert property ( // see R14
        (state_ff == ST_RECV) ##1 (state_ff != ST_RECV) |-> $past(cnt_ff) == `SBL_IMAGE_BYTES - 1'b1)
        else $error("boot left before 576 bytes");
    uart_off_a: assert property ( // see R16 R17
        (state_ff == ST_UART_OFF) |=> cfg_ff.serial_mode_register == `SBL_SCM_RESET ##1 !halt_ff)
        else $error("uart not disabled before halt release");
    end_state_a: assert property ( // see R19 R23
        (done_ff && boot_en) |-> cfg_ff.interrupt_config_register == `SBL_ICR_BOOT && cfg_ff.bar == `SBL_BAR_BOOT
                                 && state_ff == ST_IDLE && !halt_ff)
        else $error("final register images wrong");

    boot_done_c: cover property (state_ff == ST_RELEASE);
    boot_off_c: cover property ((state_ff == ST_START && !boot_en) ##1 !halt_ff);
    ext_clk_c: cover property (state_ff == ST_RECV && cfg_ff.ext_clk);
    stall_c: cover property (state_ff == ST_RECV && i_rx_valid && !echo_ready);
endmodule

/* File: hdl/sbl_strap.sv */
// Purpose: capture of the three boot straps
// Assumes: system reset is i_rst_n low, synchronous
// Notes:   clock select is taken after release, the other two only in reset
`timescale 1ns/1ps
`include "sbl_params.svh"
module sbl_strap (
    input  wire logic i_ref_clk,
    input  wire logic i_rst_n,
    input  wire logic i_boot_strap_pin,
    input  wire logic i_boot_clock_select_pin,
    input  wire logic i_freq_select_pin,
    output logic      o_boot_en,
    output logic      o_input_freq_select,
    output logic      o_clk_ext,
    output logic      o_clksel_valid
);
    logic                        boot_en_ff;
    logic                        freq_ff;
    logic                        ext_ff;
    logic                        valid_ff;
    logic [`SBL_CLKSEL_CW-1:0]   cnt_ff;

    // reset is synchronous, so the pin level is a clocked capture here
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            boot_en_ff <= ~i_boot_strap_pin;    // see R1 R18
            freq_ff    <= i_freq_select_pin;    // see R3
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            cnt_ff   <= '0;
            valid_ff <= 1'b0;
            ext_ff   <= 1'b0;
        end else if (!valid_ff) begin
            cnt_ff <= cnt_ff + 1'b1;
            if (cnt_ff == `SBL_CLKSEL_CW'(`SBL_CLKSEL_WIN - 1)) begin
                ext_ff   <= i_boot_clock_select_pin;    // see R2
                valid_ff <= 1'b1;
            end
        end
    end

    assign o_boot_en           = boot_en_ff;
    assign o_input_freq_select = freq_ff;
    assign o_clk_ext           = ext_ff;
    assign o_clksel_valid      = valid_ff;

    clksel_window_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see R2
        $rose(valid_ff) |-> $past(i_rst_n, 100) && !$past(i_rst_n, 101))
        else $error("clock select not taken at clock 100 after release");
    strap_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see R18
        $stable(boot_en_ff) && $stable(freq_ff))
        else $error("boot strap changed outside reset");
endmodule

/* File: pkg/sbl_params.svh */
// Purpose: constants of the serial boot loader (offsets, fields, reset values, counts)
// Assumes: included by the package and the loader and strap modules by bare name
// Notes:   BAR, ICR, SCON and SCM values are 16-bit register images; the rest are counts, widths, offsets, bit positions, a divider value and a multiplier
// Behaviour
// R1 - boot strap low in reset enables boot
// R2 - clock select sampled within 100 clocks
// R3 - frequency strap captured during reset
// R4 - board drives boot strap firmly, never floating
// R5 - boot enabled keeps core halted after reset
// R6 - base address image written to zero first
// R7 - external mode uses 16x pin clocks
// R8 - internal mode tristates both clock pins
// R9 - divider image 00d8 or 00a8 by strap
// R10 - 32 kHz case divider field is 84
// R11 - mode image 013d: uart, rx, tx on
// R12 - bytes stored from ram address zero
// R13 - every received byte echoed on transmit
// R14 - exactly 576 bytes before leaving boot
// R15 - host sends 576 bytes, pads with zero
// R16 - mode image cleared after final byte
// R17 - halt released after uart disabled
// R18 - boot re-entered only through system reset
// R19 - end state: icr c000, base zero
// R20 - no external master during boot
// R21 - boot only on serial channel one
// R22 - no automatic baud detection during boot
// R23 - idle after release until next reset
`ifndef SBL_PARAMS_SVH
`define SBL_PARAMS_SVH

`define SBL_CLKSEL_WIN    100
`define SBL_CLKSEL_CW     7
`define SBL_IMAGE_BYTES   10'd576
`define SBL_RAM_AW        10
`define SBL_PLL_MULT      401
`define SBL_DIV_LSB       1
`define SBL_DIV_MSB       11
`define SBL_DIV_32K       11'd84
`define SBL_BAR_BOOT      16'h0000
`define SBL_BAR_RESET     16'hffff
`define SBL_ICR_BOOT      16'hc000
`define SBL_ICR_RESET     16'h0000
`define SBL_SCON_4M       16'h00d8
`define SBL_SCON_32K      16'h00a8
`define SBL_SCON_RESET    16'h0000
`define SBL_SCM_UART      16'h013d
`define SBL_SCM_RESET     16'h0000
`define SBL_REG_CTRL      8'h00
`define SBL_REG_STATUS    8'h04
`define SBL_REG_SCC       8'h08
`define SBL_REG_SYS       8'h0c
`define SBL_CTRL_HOLD     0
`define SBL_ST_HALT       16
`define SBL_ST_BOOT       17
`define SBL_ST_EXT        18
`define SBL_ST_FREQ       19
`define SBL_ST_DONE       20
`define SBL_ST_CSVALID    21

`endif

/* File: pkg/sbl_pkg.sv */
// Purpose: types carried between the loader, its bus, its memory port and the serial channel
// Assumes: sbl_params.svh gives the widths
// Notes:   structs are packed so they can cross module ports whole
`include "sbl_params.svh"
package sbl_pkg;
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } sbl_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [31:0] dat;
    } sbl_wb_rsp_t;

    typedef struct packed {
        logic [15:0] bar;
        logic [15:0] interrupt_config_register;
        logic [15:0] scon;
        logic [15:0] serial_mode_register;
        logic        ext_clk;
        logic        clk_pins_hiz;
        logic        autobaud;
    } sbl_scc_cfg_t;

    typedef struct packed {
        logic                   we;
        logic [`SBL_RAM_AW-1:0] addr;
        logic [7:0]             data;
    } sbl_ram_wr_t;
endpackage

/* File: testbench/sbl_host_model.sv */
// Purpose: far-side uart host that streams the boot image and takes echoes
// Assumes: byte-level handshake, one byte offered at a time
// Notes:   a slow host accepts an echo only once in eight cycles
`timescale 1ns/1ps
module sbl_host_model (
    input  wire logic  i_ref_clk,
    input  wire logic  i_slow,
    input  wire logic  i_rx_ready,
    output logic       o_rx_valid,
    output logic [7:0] o_rx_data,
    output logic       o_tx_ready
);
    logic [2:0] stall_ff;

    initial begin
        o_rx_valid = 1'b0;
        o_rx_data  = 8'h00;
        o_tx_ready = 1'b1;
        stall_ff   = 3'h0;
    end

    always @(posedge i_ref_clk) begin
        stall_ff   <= stall_ff + 3'h1;
        o_tx_ready <= !i_slow || (stall_ff == 3'h7);
    end

    // offer one byte and hold it until the loader takes it
    task automatic send(input logic [7:0] b);
        o_rx_valid <= 1'b1;
        o_rx_data  <= b;
        do @(posedge i_ref_clk); while (i_rx_ready !== 1'b1);
    endtask

    // a released line must not keep showing the last byte
    task automatic release_line();
        o_rx_valid <= 1'b0;
        o_rx_data  <= ~o_rx_data;
    endtask
endmodule

/* File: testbench/sbl_loader_test.sv */
// Purpose: self-checking bench of the serial boot loader
// Assumes: expected ram writes and echoes are queued before each byte is sent
// Notes:   strap inputs flip after release to show they were latched
`timescale 1ns/1ps
module sbl_loader_test;
    import sbl_pkg::*;
    logic         clk      = 1'b0;
    logic         rst_n    = 1'b0;
    logic         boot_pin = 1'b0;
    logic         csel_pin = 1'b0;
    logic         freq_pin = 1'b0;
    logic         slow     = 1'b1;
    sbl_wb_req_t  wb_req   = '0;
    sbl_wb_rsp_t  wb_rsp;
    logic         rx_valid;
    logic         rx_ready;
    logic         tx_valid;
    logic         tx_ready;
    logic [7:0]   rx_data;
    logic [7:0]   tx_data;
    logic [7:0]   b;
    sbl_ram_wr_t  ram;
    sbl_scc_cfg_t cfg;
    logic         halt;
    logic         er;
    logic [31:0]  rd;
    logic [31:0]  rn;
    logic [31:0]  seed     = 32'h6042f217;
    logic [17:0]  ram_q[$];
    logic [7:0]   tx_q[$];
    int           error_cnt   = 0;
    int           checks_done = 0;

    always #2.5 clk = ~clk;

    sbl_loader dut_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_boot_strap_pin(boot_pin),
        .i_boot_clock_select_pin(csel_pin), .i_freq_select_pin(freq_pin), .i_wb(wb_req),
        .o_wb(wb_rsp), .i_rx_valid(rx_valid), .i_rx_data(rx_data), .o_rx_ready(rx_ready),
        .o_tx_valid(tx_valid), .o_tx_data(tx_data), .i_tx_ready(tx_ready), .o_ram(ram),
        .o_scc_cfg(cfg), .o_core_halt(halt));
    sbl_host_model host_u (.i_ref_clk(clk), .i_slow(slow), .i_rx_ready(rx_ready),
        .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_tx_ready(tx_ready));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // only the status port is touched; no master takes the system bus in boot
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
        do @(posedge clk); while (wb_rsp.ack !== 1'b1 && wb_rsp.err !== 1'b1);
        rd = wb_rsp.dat;
        er = wb_rsp.err;
        wb_req <= '0;
        @(posedge clk);
    endtask

    // straps are driven firmly through reset
    task automatic do_reset(input logic bt, input logic f, input logic c);
        rst_n    <= 1'b0;
        boot_pin <= bt;
        freq_pin <= f;
        csel_pin <= c;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (101) @(posedge clk);
        csel_pin <= ~c;
        freq_pin <= ~f;
        boot_pin <= ~bt;
        repeat (9) @(posedge clk);
    endtask

    task automatic results();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        if (ram.we === 1'b1) begin
            chk({ram.addr, ram.data}, ram_q.pop_front(), "ram write");
        end
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            chk(tx_data, tx_q.pop_front(), "echo");
        end
    end

    initial begin
        repeat (12000) @(posedge clk);
        error_cnt++;
        results();
    end

    initial begin
        do_reset(1'b0, 1'b0, 1'b0);
        chk(halt, 1'b1, "halt held");
        chk(cfg.bar, 16'h0000, "base");
        chk(cfg.scon, 16'h00d8, "divider image");
        chk(cfg.clk_pins_hiz, 1'b1, "pins hiz");
        chk(cfg.serial_mode_register, 16'h013d, "mode image");
        chk(cfg.autobaud, 1'b0, "autobaud");
        for (int i = 0; i < 576; i++) begin
            rn = xs();
            b = rn[7:0];
            if (i == 100) begin
                host_u.release_line();
                wb(1'b1, 8'h00, 32'h1);
                wb(1'b0, 8'h04, 32'h0);
                chk(rd[9:0], 10'd100, "count");
                chk(rx_ready, 1'b0, "hold stalls");
                wb(1'b1, 8'h00, 32'h0);
            end
            if (i == 575) chk(halt, 1'b1, "early release");
            slow <= (i < 40);
            ram_q.push_back({i[9:0], b});
            tx_q.push_back(b);
            host_u.send(b);
        end
        host_u.release_line();
        repeat (4) @(posedge clk);
        chk(cfg.serial_mode_register, 16'h0000, "mode cleared");
        chk(halt, 1'b0, "halt released");
        chk({cfg.interrupt_config_register, cfg.bar}, 32'hc000_0000, "end images");
        wb(1'b0, 8'h10, 32'h0);
        chk(er, 1'b1, "unmapped err");
        repeat (20) @(posedge clk);
        chk(rx_ready, 1'b0, "idle after boot");
        chk(ram_q.size() + tx_q.size(), 0, "all seen");
        for (int m = 0; m < 2; m++) begin
            do_reset(1'b0, m[0], ~m[0]);
            chk(cfg.ext_clk, !m[0], "ext clock");
            chk(cfg.clk_pins_hiz, m[0], "pins hiz");
            if (m == 1) chk(cfg.scon, 16'h00a8, "low freq image");
            if (m == 1) chk(cfg.scon[11:1], 11'd84, "divider field");
        end
        do_reset(1'b1, 1'b0, 1'b0);
        chk(halt, 1'b0, "no boot");
        chk(rx_ready, 1'b0, "no receive");
        results();
    end
endmodule
